/* File: core/bbsram_host.sv */
// Host-side controller driving a battery-backed static memory over its pins
//
// Overview of operation
// R1 - Read: strobe high, select low
// R2 - Read data valid after longest access delay
// R3 - Drive access within output enable delay
// R4 - Memory drives only with select, drive low
// R5 - Early drive gives undefined data until access
// R6 - Address change: old data briefly, then undefined
// R7 - Float within select float delay
// R8 - Float within drive float delay
// R9 - Write spans both low, ends earliest rise
// R10 - Address stable, set up before write end
// R11 - Strobe low at least strobe pulse width
// R12 - Select low at least select pulse width
// R13 - Data set up before end, held after
// R14 - Address held after strobe or select rise
// R15 - Keep drive high during writes
// R16 - Memory floats after strobe falls
// R17 - Simultaneous fall keeps bus floating
// R18 - Power fail deselects, blocks writes later
// R19 - Access underway at power fail completes
// R20 - Fast collapse: protection within limit
// R21 - Recovery interval holds protection after power
// R22 - Host waits full recovery, ignores protected access
`timescale 1ns/100ps
`default_nettype none

module bbsram_host
    import bbsram_pkg::*;
#(
    parameter int GRADE           = 0,
    parameter int RECOVERY_COUNT  = bbsram_pkg::RECOVERY_CYCLES
) (
    // Clock, reset and the host's own supply monitor
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    power_good,
    // Request side towards the host logic
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire bbsram_pkg::bbsram_req_t req,
    output logic                         resp_valid,
    output logic [bbsram_pkg::DATA_W-1:0] resp_rdata,
    output logic                         access_refused,
    // Memory pins; the data bus is split into its two directions
    output logic                         sel_n,
    output logic                         drive_n,
    output logic                         strobe_n,
    output logic [bbsram_pkg::ADDR_W-1:0] byte_address,
    output logic [bbsram_pkg::DATA_W-1:0] data_out,
    output logic                         data_oe_n,
    input  wire logic [bbsram_pkg::DATA_W-1:0] data_in
);
    import bbsram_pkg::*;

    // Timing, every figure rounded up to whole clock cycles:
    //  - a read waits the address access delay plus one cycle; select and drive
    //    fall with the address, so their shorter access delays are covered too
    //  - a write keeps select and strobe low for the longest of the strobe pulse,
    //    select pulse and address-to-end minima; data set-up is shorter still
    //  - the gap after an access covers both float delays and the address hold
    // Limitation: select and drive fall on the edge that moves the address, so
    // the memory may show undefined data early in a read; it is never taken then.
    // Trade-off: one margin cycle per read buys freedom from clock-to-pin skew.
    localparam int READ_CYC   = ns_to_cycles(ADDR_ACCESS_NS[GRADE]) + 1; // [R2] [R3] [R5]
    localparam int WPULSE_NS  = (STROBE_PULSE_NS[GRADE] > ADDR_TO_END_NS[GRADE]) ?
                                STROBE_PULSE_NS[GRADE] : ADDR_TO_END_NS[GRADE];
    localparam int WRITE_CYC  = (ns_to_cycles(WPULSE_NS) > ns_to_cycles(SELECT_PULSE_NS[GRADE]))
                                ? ns_to_cycles(WPULSE_NS)
                                : ns_to_cycles(SELECT_PULSE_NS[GRADE]); // [R11] [R12] [R13]
    localparam int FLOAT_NS   = (SELECT_FLOAT_NS[GRADE] > DRIVE_FLOAT_NS[GRADE]) ?
                                SELECT_FLOAT_NS[GRADE] : DRIVE_FLOAT_NS[GRADE];
    localparam int GAP_CYC    = (ns_to_cycles(FLOAT_NS) > ns_to_cycles(SELECT_ADDR_HOLD_NS))
                                ? ns_to_cycles(FLOAT_NS) : ns_to_cycles(SELECT_ADDR_HOLD_NS);
    localparam int CW         = $clog2(RECOVERY_COUNT + 1);

    // The one down-counter serves every wait, so it must be wide enough for all
    // of them; a grade outside the table has no timing to offer
    if (GRADE < 0 || GRADE > 2 || RECOVERY_COUNT < READ_CYC || RECOVERY_COUNT < WRITE_CYC
        || RECOVERY_COUNT < GAP_CYC) begin : g_bad_param
        $error("bbsram_host: unsupported grade or recovery count");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state, shared counter, latched command and the answer
    bbsram_state_t     state_reg, state_next;
    logic [CW-1:0]     count_reg, count_next;
    bbsram_req_t       cmd_reg, cmd_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              resp_reg, resp_next;
    logic              refused_reg, refused_next;
    logic              power_seen_reg;

    wire logic count_done = (count_reg == '0);
    wire logic is_write   = cmd_reg.write;
    // power_good stands for the supply monitor and is taken as synchronous.
    // Protection seen: new work is refused, a started cycle is allowed to finish
    wire logic protected_now = !power_good;                          // [R18] [R19] [R20]
    wire logic take         = (state_reg == ST_IDLE) && req_valid && !protected_now;
    // Power must stay good from the take to the end of the gap; a dip anywhere in
    // between sends the controller through a full recovery afterwards
    wire logic power_seen_next = power_good && (power_seen_reg || take);  // [R19] [R21]

    // Handshake and answer outputs; the answer comes straight from flip-flops
    assign req_ready      = (state_reg == ST_IDLE);
    assign resp_valid     = resp_reg;
    assign resp_rdata     = rdata_reg;
    assign access_refused = refused_reg;

    // Pin decode: select and strobe fall together in the setup state for writes
    wire logic in_cycle = (state_reg == ST_SETUP) || (state_reg == ST_ACTIVE);
    assign sel_n        = !in_cycle;                                 // [R1] [R9]
    assign strobe_n     = !(in_cycle && is_write);                   // [R9] [R17]
    assign drive_n      = !(in_cycle && !is_write);                  // [R4] [R15]
    assign byte_address = cmd_reg.byte_address;                      // [R10] [R14]
    assign data_out     = cmd_reg.wdata;                             // [R13]
    // Host drives the bus only during writes, low enable means driving. The drive
    // lasts into the first gap cycle, so data outlasts the select rise by 16 ns
    wire logic hold_data   = (state_reg == ST_GAP) && (count_reg == CW'(GAP_CYC));
    wire logic host_drives = in_cycle || (state_reg == ST_HOLD) || hold_data;
    assign data_oe_n    = !(host_drives && is_write);                    // [R13] [R16]

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: RECOVER -> IDLE -> SETUP -> ACTIVE -> HOLD -> GAP -> IDLE.
    // One down-counter times recovery, the access and the gap in turn; it is
    // reloaded on every state change that starts a wait, so nothing carries over.
    always_comb begin
        state_next   = state_reg;
        count_next   = count_done ? count_reg : count_reg - 1'b1;
        cmd_next     = cmd_reg;
        rdata_next   = rdata_reg;
        resp_next    = 1'b0;
        refused_next = 1'b0;
        case (state_reg)
            ST_RECOVER: begin
                // Power must stay good for the whole recovery interval;
                // any dip restarts the count from the top
                if (!power_good) begin
                    count_next = CW'(RECOVERY_COUNT);                // [R21] [R22]
                end else if (count_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // A request under bad supply is refused and reported, never queued
                if (protected_now) begin
                    state_next   = ST_RECOVER;
                    count_next   = CW'(RECOVERY_COUNT);
                    refused_next = req_valid;                        // [R22]
                end else if (take) begin
                    cmd_next   = req;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address, select and strobe move on one edge; zero set-up to the
                // falling edge is allowed, and this cycle counts towards the pulse
                state_next = ST_ACTIVE;
                count_next = CW'(is_write ? WRITE_CYC - 1 : READ_CYC - 1);
            end
            ST_ACTIVE: begin
                // Read data is taken on the last low cycle, past every access delay
                if (count_done) begin
                    if (!is_write) begin
                        rdata_next = data_in;                        // [R2] [R6]
                        resp_next  = 1'b1;
                    end else begin
                        resp_next  = 1'b1;
                    end
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data and address held past the write end edge;
                // select and strobe are already high here
                state_next = ST_GAP;
                count_next = CW'(GAP_CYC);                           // [R7] [R8] [R14]
            end
            ST_GAP: begin
                // Bus has floated and the address hold is over; a supply dip since
                // the take means a fresh recovery interval before the next access
                if (count_done) begin
                    state_next = power_seen_reg ? ST_IDLE : ST_RECOVER;
                    if (!power_seen_reg) begin
                        count_next = CW'(RECOVERY_COUNT);
                    end
                end
            end
            default: begin
                // Unused codes fall back to a full recovery, as after power-up
                state_next = ST_RECOVER;
                count_next = CW'(RECOVERY_COUNT);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers; recovery starts from reset as after power-up.
    // Reset leaves every memory pin inactive from the first edge on.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg      <= ST_RECOVER;
            count_reg      <= CW'(RECOVERY_COUNT);
            cmd_reg        <= '0;
            rdata_reg      <= '0;
            resp_reg       <= 1'b0;
            refused_reg    <= 1'b0;
            power_seen_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            count_reg      <= count_next;
            cmd_reg        <= cmd_next;
            rdata_reg      <= rdata_next;
            resp_reg       <= resp_next;
            refused_reg    <= refused_next;
            power_seen_reg <= power_seen_next;
        end
    end

endmodule : bbsram_host
`default_nettype wire

/* File: core/bbsram_pkg.sv */
// Package for the battery-backed SRAM host port controller
package bbsram_pkg;

    localparam int CLK_PERIOD_PS = 8000;

    // Speed grade table: index 0, 1, 2 for the fast, middle and slow grade (ns)
    localparam int ADDR_ACCESS_NS [3]   = '{70, 85, 120};
    localparam int DRIVE_FLOAT_NS [3]   = '{20, 25, 35};
    localparam int SELECT_FLOAT_NS [3]  = '{30, 35, 45};
    localparam int STROBE_PULSE_NS [3]  = '{55, 65, 85};
    localparam int SELECT_PULSE_NS [3]  = '{55, 75, 100};
    localparam int ADDR_TO_END_NS [3]   = '{65, 75, 100};
    localparam int DATA_SETUP_NS [3]    = '{30, 35, 45};
    localparam int STROBE_ADDR_HOLD_NS  = 5;
    localparam int SELECT_ADDR_HOLD_NS  = 15;
    localparam int STROBE_DATA_HOLD_NS  = 0;
    localparam int RECOVERY_MAX_MS      = 120;
    localparam int PROTECT_MAX_US       = 250;

    // Least time in ns to whole clock cycles, rounded up, at least one
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    // One millisecond is 1e9 ps; dividing first keeps the product inside 32 bits
    localparam int RECOVERY_CYCLES = RECOVERY_MAX_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int PROTECT_CYCLES  = PROTECT_MAX_US * (1000000 / CLK_PERIOD_PS);

    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // Host command request: direction, byte address and write data
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] byte_address;
        logic [DATA_W-1:0] wdata;
    } bbsram_req_t;

    // Memory pins driven by the controller
    typedef struct packed {
        logic              sel_n;
        logic              drive_n;
        logic              strobe_n;
        logic [ADDR_W-1:0] byte_address;
        logic [DATA_W-1:0] data_out;
        logic              data_oe_n;
    } bbsram_pins_t;

    typedef enum logic [2:0] {
        ST_RECOVER = 3'b000,
        ST_IDLE    = 3'b001,
        ST_SETUP   = 3'b011,
        ST_ACTIVE  = 3'b010,
        ST_HOLD    = 3'b110,
        ST_GAP     = 3'b111
    } bbsram_state_t;

endpackage : bbsram_pkg

/* File: verif/bbsram_host_props.sv */
// Checker of the host port pin sequencing
`timescale 1ns/100ps
`default_nettype none
module bbsram_host_props
    import bbsram_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          rst,
    input wire logic                          power_good,
    input wire logic                          req_valid,
    input wire logic                          req_ready,
    input wire logic                          resp_valid,
    input wire logic                          access_refused,
    input wire logic                          sel_n,
    input wire logic                          drive_n,
    input wire logic                          strobe_n,
    input wire logic [bbsram_pkg::ADDR_W-1:0] byte_address,
    input wire logic [bbsram_pkg::DATA_W-1:0] data_out,
    input wire logic                          data_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Widths are for the fast grade at 8 ns, 7 cycles cover 55 ns
    a_drive_kept_high: assert property (!strobe_n |-> drive_n)
        else $error("output enable low during write");
    a_falls_together: assert property ($fell(strobe_n) |-> $fell(sel_n))
        else $error("strobe fell apart from select");
    a_strobe_width: assert property ($fell(strobe_n) |-> !strobe_n [*7])
        else $error("strobe pulse too short");
    a_select_width: assert property ($fell(sel_n) |-> !sel_n [*7])
        else $error("select pulse too short");
    a_address_held: assert property (!sel_n |=> $stable(byte_address))
        else $error("address moved in or right after access");
    a_data_held: assert property (!strobe_n |=> !data_oe_n && $stable(data_out))
        else $error("write data not held");
    a_end_answers: assert property ($rose(sel_n) |-> resp_valid)
        else $error("access end without answer");
    a_refuse_blocks: assert property (req_valid && req_ready && !power_good
        |=> access_refused && sel_n)
        else $error("request under bad power not refused");
    a_recover_wait: assert property ($rose(power_good) |-> !req_ready [*8])
        else $error("ready too soon after power return");
    c_write: cover property ($rose(strobe_n));
    c_read: cover property ($rose(drive_n));
    c_refused: cover property (access_refused);
endmodule : bbsram_host_props
`default_nettype wire

/* File: verif/bbsram_mem_model.sv */
// Behavioural battery-backed memory seen from its pins
`timescale 1ns/100ps
`default_nettype none
module bbsram_mem_model
    import bbsram_pkg::*;
#(
    parameter int GRADE = 0
) (
    input  wire logic [bbsram_pkg::ADDR_W-1:0] byte_address,
    input  wire logic                          sel_n,
    input  wire logic                          drive_n,
    input  wire logic                          strobe_n,
    input  wire logic [bbsram_pkg::DATA_W-1:0] data_out,
    output logic      [bbsram_pkg::DATA_W-1:0] data_in
);
    localparam int DRIVE_ACC [3] = '{35, 45, 60};
    logic [7:0] mem [int];
    realtime    t_addr;
    realtime    t_drive;
    logic       wr = 1'b0;
    // A new address or select restarts the access timer
    always @(byte_address or sel_n) t_addr = $realtime;
    always @(drive_n) t_drive = $realtime;
    // Store at the earlier rising edge of select or strobe
    always @(sel_n or strobe_n) begin
        if (wr && (sel_n || strobe_n)) mem[byte_address] = data_out;
        wr = !sel_n && !strobe_n;
    end
    // Off the bus the line toggles, so a late sample sees either the old byte or its inverse
    initial begin
        data_in = 8'h00;
        forever begin
            #1;
            if (!sel_n && !drive_n && strobe_n && $realtime - t_addr >= ADDR_ACCESS_NS[GRADE]
                && $realtime - t_drive >= DRIVE_ACC[GRADE])
                data_in = mem.exists(byte_address) ? mem[byte_address] : 8'h5a;
            else data_in = ~data_in;
        end
    end
endmodule : bbsram_mem_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench of the host port controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bbsram_pkg::*;
    localparam int REC = 20;
    logic              clock, rst, power_good, req_valid, req_ready, resp_valid;
    logic              access_refused, sel_n, drive_n, strobe_n, data_oe_n;
    bbsram_req_t       req;
    logic [ADDR_W-1:0] byte_address;
    logic [ADDR_W-1:0] a [8];
    logic [DATA_W-1:0] resp_rdata, data_out, data_in;
    logic [7:0]        ref_mem [int];
    logic [31:0]       lfsr_state = 32'h08067c3f;
    int                mismatches = 0, num_checks = 0, cycles = 0, n;
    bbsram_host #(.GRADE(0), .RECOVERY_COUNT(REC)) bbsram_host_i (.clock, .rst, .power_good,
        .req_valid, .req_ready, .req, .resp_valid, .resp_rdata, .access_refused, .sel_n,
        .drive_n, .strobe_n, .byte_address, .data_out, .data_oe_n, .data_in);
    bbsram_mem_model #(.GRADE(0)) bbsram_mem_model_i (.byte_address, .sel_n, .drive_n,
        .strobe_n, .data_out, .data_in);
    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic wait_ready(output int k);
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin
            @(posedge clock) #1;
            k++;
        end
    endtask : wait_ready
    // One request; answer delay is fixed by the fast grade timing
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [7:0] d);
        int k;
        req_valid = 1'b1;
        req = '{write: w, byte_address: ad, wdata: d};
        wait_ready(k);
        @(posedge clock) #1;
        req_valid = 1'b0;
        k = 1;
        while (resp_valid !== 1'b1 && k < 40) begin
            @(posedge clock) #1;
            k++;
        end
        check("answer delay", k, w ? 11 : 12);
        if (w) ref_mem[ad] = d;
        else check("read data", resp_rdata, ref_mem[ad]);
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // A hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1; power_good = 1'b1; req_valid = 1'b0; req = '0;
        repeat (3) @(posedge clock);
        #1 rst = 1'b0;
        wait_ready(n);
        check("recovery wait", n, REC + 1);
        // Corner addresses first, then random bytes, read back in reverse
        for (int i = 0; i < 8; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            a[i] = (i == 0) ? '0 : (i == 1) ? '1 : lfsr_state[16:0];
            xfer(1'b1, a[i], lfsr_state[31:24]);
        end
        for (int i = 7; i >= 0; i--) xfer(1'b0, a[i], 8'h00);
        wait_ready(n);
        power_good = 1'b0;
        req_valid = 1'b1;
        n = 0;
        while (access_refused !== 1'b1 && n < 5) begin
            @(posedge clock) #1;
            n++;
        end
        req_valid = 1'b0;
        check("refused", n, 1);
        repeat (4) @(posedge clock);
        #1 power_good = 1'b1;
        wait_ready(n);
        check("recovery after fail", n, REC + 1);
        // Supply drops in mid-write; the write still lands
        fork
            xfer(1'b1, 17'h0abcd, 8'ha5);
            begin
                repeat (4) @(posedge clock);
                #1 power_good = 1'b0;
            end
        join
        power_good = 1'b1;
        // Hold and gap take 6 cycles, then a full recovery because of the dip
        wait_ready(n);
        check("recovery after cut write", n, REC + 7);
        xfer(1'b0, 17'h0abcd, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
bind bbsram_host bbsram_host_props bbsram_host_props_i (.clock, .rst, .power_good, .req_valid,
    .req_ready, .resp_valid, .access_refused, .sel_n, .drive_n, .strobe_n, .byte_address,
    .data_out, .data_oe_n);
`default_nettype wire
